// file: pkg/ris_pkg.sv
/*
  Shared constants and types of the event status block of the real-time clock:
  register offsets, bit positions, reset values, the event bundle and the bus states.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package ris_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int EVT_N = 18;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADR_W-1:0] RAW_OFS = 8'h2C;
  localparam logic [ADR_W-1:0] MSK_OFS = 8'h30;
  localparam logic [ADR_W-1:0] IEN_OFS = 8'h34;
  localparam logic [ADR_W-1:0] CLR_OFS = 8'h38;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions inside both status views
  localparam int TICK_BIT  = 17;
  localparam int WRAP_HI   = 16;
  localparam int WRAP_LO   = 9;
  localparam int ALARM_HI  = 8;
  localparam int ALARM_LO  = 0;
  localparam int RSVD_LO   = 18;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [EVT_N-1:0] EVT_RST  = 18'h00000;
  localparam logic [EVT_N-1:0] IEN_RST  = 18'h3FFFF;
  localparam logic [DAT_W-1:0] DAT_RST  = 32'h00000000;
  localparam logic [DAT_W-EVT_N-1:0] RSVD_ZERO = 14'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // One bit per calendar event, declared in view order from bit 17 down to bit 0; packing fixes the layout
  typedef struct packed {
    logic second_tick;
    logic century_wrap;
    logic year_wrap;
    logic month_wrap;
    logic day_wrap;
    logic weekday_wrap;
    logic hour_wrap;
    logic minute_wrap;
    logic second_wrap;
    logic full_alarm;
    logic century_alarm;
    logic year_alarm;
    logic month_alarm;
    logic day_alarm;
    logic weekday_alarm;
    logic hour_alarm;
    logic minute_alarm;
    logic second_alarm;
  } ris_evt_t;

  typedef enum logic [1:0] {
    RIS_BUS_IDLE = 2'b01,
    RIS_BUS_ACK  = 2'b10
  } ris_bus_state_t;

  typedef enum logic [2:0] {
    RIS_SEL_NONE = 3'h0,
    RIS_SEL_RAW  = 3'h1,
    RIS_SEL_MSK  = 3'h2,
    RIS_SEL_IEN  = 3'h3,
    RIS_SEL_CLR  = 3'h4
  } ris_reg_sel_t;

endpackage

// file: src/ris_top.sv
/*
  Event status block of the real-time clock: raw and masked status of eighteen
  calendar events, a write-one-to-clear path, an interrupt enable and one
  level interrupt, behind a classic Wishbone slave.
  Assumes the counters and alarm comparators deliver one-cycle event pulses
  synchronous to clk_i, and that the mask bits come in as static levels.
*/
// Chosen here: the Wishbone register port.
// Behaviour
// - The raw status word sits read-only at 0x2C and bit n reads 1 while event n is pending, whatever the mask.
// - Bit 17 of both views is the once-per-second tick event.
// - Bits 16 to 9 of both views are the century, year, month, date, week, hour, minute and second rollovers.
// - Bits 8 to 0 of both views are the all-fields, century, year, month, date, week, hour, minute and second alarms.
// - Raw bits 31 to 18 are reserved, read as zero and ignore writes; software leaves them alone.
// - A masked bit reads 1 once its event was signalled while its mask passed it and 0 if none occurred or its mask blocks it.
// - Writing 1 to a masked status bit 17 to 0 clears that bit; software writes ones only where it clears.
// - Every raw and masked status bit is 0 after reset.
// - A mask bit at 1 passes its event into the masked view, at 0 blocks it; the mask is an input level with no reset of its own here.
`timescale 1ns/1ps

module ris_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ris_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [ris_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [ris_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [ris_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  input  wire ris_pkg::ris_evt_t           event_pulse_i,
  input  wire ris_pkg::ris_evt_t           event_mask_register_i,
  output logic                             irq_o
);
  import ris_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Fixes the bit layout of both status views from the event bundle
  function automatic logic [EVT_N-1:0] pack_evt(input ris_evt_t e);
    logic [EVT_N-1:0] v;
    v = EVT_RST;
    v[TICK_BIT] = e.second_tick;
    v[WRAP_HI:WRAP_LO] = {e.century_wrap, e.year_wrap, e.month_wrap,
                          e.day_wrap, e.weekday_wrap, e.hour_wrap,
                          e.minute_wrap, e.second_wrap};
    v[ALARM_HI:ALARM_LO] = {e.full_alarm, e.century_alarm, e.year_alarm,
                            e.month_alarm, e.day_alarm, e.weekday_alarm,
                            e.hour_alarm, e.minute_alarm, e.second_alarm};
    return v;
  endfunction

  // Byte enables widened to one bit per data bit
  function automatic logic [DAT_W-1:0] byte_mask(input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] m;
    m = DAT_RST;
    for (int i = 0; i < SEL_W; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // Low two address bits are ignored: every register is one aligned word
  function automatic ris_reg_sel_t decode(input logic [ADR_W-1:0] a);
    ris_reg_sel_t s;
    s = RIS_SEL_NONE;
    if (a[ADR_W-1:2] == RAW_OFS[ADR_W-1:2]) begin
      s = RIS_SEL_RAW;
    end else if (a[ADR_W-1:2] == MSK_OFS[ADR_W-1:2]) begin
      s = RIS_SEL_MSK;
    end else if (a[ADR_W-1:2] == IEN_OFS[ADR_W-1:2]) begin
      s = RIS_SEL_IEN;
    end else if (a[ADR_W-1:2] == CLR_OFS[ADR_W-1:2]) begin
      s = RIS_SEL_CLR;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  ris_bus_state_t          state_r;
  ris_bus_state_t          state_nxt;
  logic [DAT_W-1:0]        dat_r;
  logic [DAT_W-1:0]        dat_nxt;
  logic [EVT_N-1:0]        raw_r;
  logic [EVT_N-1:0]        raw_nxt;
  logic [EVT_N-1:0]        masked_r;
  logic [EVT_N-1:0]        masked_nxt;
  logic [EVT_N-1:0]        ien_r;
  logic [EVT_N-1:0]        ien_nxt;
  logic [EVT_N-1:0]        pulse_v;
  logic [EVT_N-1:0]        mask_v;
  logic [EVT_N-1:0]        masked_view;
  logic [EVT_N-1:0]        wr_bits;
  logic [EVT_N-1:0]        clr_v;
  logic [DAT_W-1:0]        lane_en;
  logic                    commit;
  ris_reg_sel_t            sel;

  assign pulse_v = pack_evt(event_pulse_i);
  assign mask_v  = pack_evt(event_mask_register_i);
  assign sel     = decode(wb_adr_i);

  // Write takes effect at the edge on which the master samples ack
  assign commit  = (state_r == RIS_BUS_ACK) && wb_cyc_i && wb_stb_i && wb_we_i;
  // A function result cannot be part-selected, so the widened enables get their own net
  assign lane_en = byte_mask(wb_sel_i);
  assign wr_bits = wb_dat_i[EVT_N-1:0] & lane_en[EVT_N-1:0];

  // Zeros written keep their bits; reserved lanes above bit 17 are dropped
  assign clr_v = (commit && (sel == RIS_SEL_MSK || sel == RIS_SEL_CLR)) ? wr_bits : EVT_RST;

  // A bit whose mask is low reads 0 even if it was caught earlier
  assign masked_view = masked_r & mask_v;

  ////////////////////////////////////////////////////////////////////////////////
  // Event status

  always_comb begin
    // Set wins over a clear in the same cycle so no event is lost
    raw_nxt    = (raw_r & ~clr_v) | pulse_v;
    masked_nxt = (masked_r & ~clr_v) | (pulse_v & mask_v);
    ien_nxt    = ien_r;
    if (commit && sel == RIS_SEL_IEN) begin
      ien_nxt = (ien_r & ~lane_en[EVT_N-1:0]) | wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_r    <= EVT_RST;
      masked_r <= EVT_RST;
      ien_r    <= IEN_RST;
    end else begin
      raw_r    <= raw_nxt;
      masked_r <= masked_nxt;
      ien_r    <= ien_nxt;
    end
  end

  // Enable resets to all ones so that out of reset the request is the plain OR
  assign irq_o = |(masked_view & ien_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  always_comb begin
    state_nxt = state_r;
    dat_nxt   = dat_r;
    case (state_r)
      RIS_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_nxt = RIS_BUS_ACK;
          dat_nxt   = DAT_RST;
          if (!wb_we_i) begin
            if (sel == RIS_SEL_RAW) begin
              dat_nxt = {RSVD_ZERO, raw_r};
            end else if (sel == RIS_SEL_MSK) begin
              dat_nxt = {RSVD_ZERO, masked_view};
            end else if (sel == RIS_SEL_IEN) begin
              dat_nxt = {RSVD_ZERO, ien_r};
            end
          end
        end
      end
      RIS_BUS_ACK: begin
        // Ack lasts one cycle; the master must drop the strobe after it
        state_nxt = RIS_BUS_IDLE;
      end
      default: begin
        state_nxt = RIS_BUS_IDLE;
        dat_nxt   = DAT_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RIS_BUS_IDLE;
      dat_r   <= DAT_RST;
    end else begin
      state_r <= state_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign wb_ack_o = (state_r == RIS_BUS_ACK);
  assign wb_dat_o = dat_r;

endmodule

// file: tb/ris_sva.sv
/* Port checker of ris_top.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module ris_sva (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [ris_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire ris_pkg::ris_evt_t         event_pulse_i,
  input wire ris_pkg::ris_evt_t         event_mask_register_i,
  input wire logic                      irq_o
);
  import ris_pkg::*;
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  ack_late_a: assert property (req |=> wb_ack_o) else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
  rsvd_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:RSVD_LO] == RSVD_ZERO)
    else $error("reserved bits set");
  reset_clean_a: assert property ($fell(rst_i) |-> !irq_o && !wb_ack_o && wb_dat_o == DAT_RST)
    else $error("not clean after reset");
  irq_gate_a: assert property (irq_o |-> (|event_mask_register_i)) else $error("irq unmasked");
  // A write or a mask change may drop the request; nothing else may
  irq_keep_a: assert property ($past(irq_o) && !$past(wb_ack_o && wb_we_i)
    && $stable(event_mask_register_i) |-> irq_o) else $error("irq dropped");
  irq_cause_a: assert property ($rose(irq_o) |-> $past(|(event_pulse_i & event_mask_register_i))
    || $past(wb_ack_o && wb_we_i) || $changed(event_mask_register_i)) else $error("irq uncaused");
endmodule
bind ris_top ris_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_pulse_i(event_pulse_i),
  .event_mask_register_i(event_mask_register_i), .irq_o(irq_o));

// file: tb/ris_top_tb.sv
/* Bench of ris_top: bus, events and mask driven here.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
module ris_top_tb;
  import ris_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h00000000, rdat, rd, rnd = 32'hD11B562C;
  logic [7:0]  ofs [5] = '{RAW_OFS, MSK_OFS, IEN_OFS, CLR_OFS, 8'h44};
  ris_evt_t    ev = '0, msk = '0;
  int          num_errors = 0, total_checks = 0, cycles = 0;
  always #4 clk_i = ~clk_i;
  ris_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .event_pulse_i(ev),
    .event_mask_register_i(msk), .irq_o(irq));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request stands until ack is sampled, so slow answers are tolerated
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic pulse(input ris_evt_t v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, RAW_OFS, 32'hFFFFFFFF, 4'hF);
    for (int k = 0; k < 5; k++) begin
      wb(1'b0, ofs[k], 32'h00000000, 4'hF);
      chk(rd, ofs[k] == IEN_OFS ? 32'(IEN_RST) : DAT_RST);
    end
    $display("reset test done");
    for (int i = 0; i < EVT_N; i++) begin
      rnd = lfsr(rnd);
      msk <= rnd[EVT_N-1:0];
      pulse(ris_evt_t'(18'h00001 << i));
      #1 chk(32'(irq), 32'(rnd[i]));
      wb(1'b0, RAW_OFS, 32'h00000000, 4'hF);
      chk(rd, 32'h1 << i);
      wb(1'b0, MSK_OFS, 32'h00000000, 4'hF);
      chk(rd, 32'(rnd[i]) << i);
      // Zeros and disabled bytes must both leave the bit pending
      wb(1'b1, MSK_OFS, 32'h3FFFF ^ (32'h1 << i), 4'hF);
      wb(1'b1, CLR_OFS, 32'h1 << i, 4'h0);
      wb(1'b0, RAW_OFS, 32'h00000000, 4'hF);
      chk(rd, 32'h1 << i);
      wb(1'b1, rnd[20] ? CLR_OFS : MSK_OFS, 32'h1 << i, 4'hF);
      wb(1'b0, RAW_OFS, 32'h00000000, 4'hF);
      chk(rd, DAT_RST);
    end
    $display("event test done");
    msk <= '1;
    pulse(ris_evt_t'(18'h00100));
    wb(1'b1, IEN_OFS, 32'h00000000, 4'hF);
    #1 chk(32'(irq), 32'h0);
    @(posedge clk_i) msk <= '0;
    wb(1'b0, MSK_OFS, 32'h00000000, 4'hF);
    chk(rd, DAT_RST);
    msk <= '1;
    wb(1'b0, MSK_OFS, 32'h00000000, 4'hF);
    chk(rd, 32'h100);
    wb(1'b1, IEN_OFS, 32'(IEN_RST), 4'hF);
    #1 chk(32'(irq), 32'h1);
    wb(1'b1, CLR_OFS, 32'h100, 4'hF);
    #1 chk(32'(irq), 32'h0);
    $display("enable test done");
    final_report();
  end
endmodule
